// File: exposure_seq.v
// Exposure sequencer with trigger-driven streaming, single-shot and bulb modes and a software-started free-run mode.
`include "exposure_seq_regs.vh"

module exposure_seq (
  input  wire                      clock,
  input  wire                      rst,
  input  wire                      trigger_in,
  input  wire [1:0]                external_start_select,
  input  wire                      start_edge_polarity,
  input  wire [`FRAME_CNT_W-1:0]   frames_per_trigger,
  input  wire [`TIME_W-1:0]        exposure_cycles,
  input  wire [`TIME_W-1:0]        repeat_cycles,
  input  wire                      arm,
  input  wire                      capture_start,
  input  wire                      stop,
  input  wire                      readout_done,
  output reg                       exposure_active,
  output reg                       readout_start,
  output reg                       busy
);

  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_EXPOSE  = 3'h1;
  localparam [2:0] ST_BULB    = 3'h2;
  localparam [2:0] ST_READOUT = 3'h3;
  localparam [2:0] ST_WAIT    = 3'h4;
  localparam [2:0] ST_LOCKED  = 3'h5;

  reg                    sync1_r;
  reg                    sync2_r;
  reg                    trig_prev_r;
  reg [2:0]              state_r;
  reg [2:0]              state_nxt;
  reg [`TIME_W-1:0]      exp_cnt_r;
  reg [`TIME_W-1:0]      exp_cnt_nxt;
  reg [`TIME_W-1:0]      rep_cnt_r;
  reg [`TIME_W-1:0]      rep_cnt_nxt;
  reg [`FRAME_CNT_W-1:0] frames_left_r;
  reg [`FRAME_CNT_W-1:0] frames_left_nxt;
  reg                    streaming_r;
  reg                    streaming_nxt;
  reg                    freerun_r;
  reg                    freerun_nxt;
  reg                    readout_start_nxt;
  reg                    load_timers;
  reg                    load_frames;
  reg                    count_frame;

  wire level_active;
  wire start_edge;
  wire end_edge;
  wire sel_none;
  wire sel_std;
  wire sel_bulb;
  wire std_stream;
  wire rep_done;
  wire free_start;
  wire bulb_start;
  wire std_start;
  wire exposure_active_nxt;
  wire busy_nxt;

  // Only the second and third stages are looked at; the first may be metastable.
  always @(posedge clock) begin
    if (rst) begin
      // Loading the idle level keeps a false edge from following reset.
      sync1_r     <= ~start_edge_polarity;
      sync2_r     <= ~start_edge_polarity;
      trig_prev_r <= ~start_edge_polarity;
    end else begin
      sync1_r     <= trigger_in;
      sync2_r     <= sync1_r;
      trig_prev_r <= sync2_r;
    end
  end

  // Polarity folds into the level so every mode sees one "active" sense.
  assign level_active = (start_edge_polarity == `POL_ACTIVE_HIGH) ? sync2_r : ~sync2_r;
  assign start_edge   = (sync2_r != trig_prev_r) && level_active;
  assign end_edge     = (sync2_r != trig_prev_r) && !level_active;

  // Mode choice looks only at trigger settings, never at readout settings.
  assign sel_none   = (external_start_select == `TRIG_SEL_NONE);
  assign sel_std    = (external_start_select == `TRIG_SEL_STANDARD);
  assign sel_bulb   = (external_start_select == `TRIG_SEL_PULSE);
  assign std_stream = (frames_per_trigger != `FRAMES_ONE);
  assign rep_done   = (rep_cnt_r <= 32'h00000001);

  // Hardware starts need arm; the software capture only needs free-run select.
  assign free_start = sel_none && capture_start;
  assign bulb_start = arm && sel_bulb && start_edge;
  assign std_start  = arm && sel_std && start_edge;

  always @* begin
    state_nxt         = state_r;
    streaming_nxt     = streaming_r;
    freerun_nxt       = freerun_r;
    load_timers       = 1'b0;
    load_frames       = 1'b0;
    count_frame       = 1'b0;
    readout_start_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (free_start) begin
          // Free run: count zero is taken as one frame.
          freerun_nxt   = 1'b1;
          streaming_nxt = 1'b0;
          load_frames   = 1'b1;
          load_timers   = 1'b1;
          state_nxt     = ST_EXPOSE;
        end else if (bulb_start) begin
          freerun_nxt   = 1'b0;
          streaming_nxt = 1'b0;
          state_nxt     = ST_BULB;
        end else if (std_start) begin
          freerun_nxt   = 1'b0;
          streaming_nxt = std_stream;
          load_timers   = 1'b1;
          state_nxt     = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (stop) begin
          // An aborted exposure is dropped, not read out.
          state_nxt = ST_IDLE;
        end else if (exp_cnt_r <= 32'h00000001) begin
          readout_start_nxt = 1'b1;
          state_nxt         = ST_READOUT;
        end
      end
      ST_BULB: begin
        // Stop drops the bulb frame; the end edge hands it to readout.
        if (stop) begin
          state_nxt = ST_IDLE;
        end else if (end_edge) begin
          readout_start_nxt = 1'b1;
          state_nxt         = ST_READOUT;
        end
      end
      ST_READOUT: begin
        // Trigger edges are not looked at here at all.
        if (readout_done) begin
          if (streaming_r) begin
            state_nxt = stop ? ST_IDLE : ST_WAIT;
          end else if (freerun_r && (frames_left_r > 16'h0001) && !stop) begin
            count_frame = 1'b1;
            state_nxt   = ST_WAIT;
          end else if (!freerun_r && !sel_none && arm && !stop) begin
            state_nxt = ST_LOCKED;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_WAIT: begin
        // Streaming ignores the trigger; only software stop ends it.
        if (stop) begin
          state_nxt = ST_IDLE;
        end else if (rep_done) begin
          load_timers = 1'b1;
          state_nxt   = ST_EXPOSE;
        end
      end
      ST_LOCKED: begin
        // A level already active after readout is not a new edge.
        if (stop || !arm || sel_none) begin
          state_nxt = ST_IDLE;
        end else if (bulb_start) begin
          state_nxt = ST_BULB;
        end else if (std_start) begin
          streaming_nxt = std_stream;
          load_timers   = 1'b1;
          state_nxt     = ST_EXPOSE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Both timers load together at each timed exposure start, so the repeat
  // interval runs from exposure start and not from the end of readout.
  always @* begin
    if (load_timers) begin
      exp_cnt_nxt = exposure_cycles;
    end else if ((state_r == ST_EXPOSE) && (exp_cnt_r > 32'h00000001)) begin
      exp_cnt_nxt = exp_cnt_r - 32'h00000001;
    end else begin
      exp_cnt_nxt = exp_cnt_r;
    end
  end

  always @* begin
    if (load_timers) begin
      rep_cnt_nxt = repeat_cycles;
    end else if (rep_cnt_r != `TIME_ZERO) begin
      rep_cnt_nxt = rep_cnt_r - 32'h00000001;
    end else begin
      rep_cnt_nxt = rep_cnt_r;
    end
  end

  // A count of zero loads as zero and still ends after the first frame.
  always @* begin
    if (load_frames) begin
      frames_left_nxt = frames_per_trigger;
    end else if (count_frame) begin
      frames_left_nxt = frames_left_r - 16'h0001;
    end else begin
      frames_left_nxt = frames_left_r;
    end
  end

  // Outputs are decoded from the next state so they move with the state register.
  assign exposure_active_nxt = (state_nxt == ST_EXPOSE) || (state_nxt == ST_BULB);
  assign busy_nxt            = (state_nxt != ST_IDLE) && (state_nxt != ST_LOCKED);

  always @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      exp_cnt_r <= `TIME_ZERO;
    end else begin
      exp_cnt_r <= exp_cnt_nxt;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      rep_cnt_r <= `TIME_ZERO;
    end else begin
      rep_cnt_r <= rep_cnt_nxt;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      frames_left_r <= `FRAMES_ZERO;
    end else begin
      frames_left_r <= frames_left_nxt;
    end
  end

  // The mode is latched at the triggered start and held through the repeats, so a later
  // change of the frame count setting does not turn a running stream into single shots.
  always @(posedge clock) begin
    if (rst) begin
      streaming_r <= 1'b0;
      freerun_r   <= 1'b0;
    end else begin
      streaming_r <= streaming_nxt;
      freerun_r   <= freerun_nxt;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      exposure_active <= 1'b0;
    end else begin
      exposure_active <= exposure_active_nxt;
    end
  end

  // A single-cycle pulse; the readout engine runs on from it by itself.
  always @(posedge clock) begin
    if (rst) begin
      readout_start <= 1'b0;
    end else begin
      readout_start <= readout_start_nxt;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= busy_nxt;
    end
  end

endmodule // exposure_seq

// File: exposure_seq_properties.sv
// Port-level assertions of the exposure sequencer.
`include "exposure_seq_regs.vh"
module exposure_seq_properties (
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic                    trigger_in,
  input wire logic [1:0]              external_start_select,
  input wire logic                    start_edge_polarity,
  input wire logic [`FRAME_CNT_W-1:0] frames_per_trigger,
  input wire logic [`TIME_W-1:0]      exposure_cycles,
  input wire logic [`TIME_W-1:0]      repeat_cycles,
  input wire logic                    arm,
  input wire logic                    capture_start,
  input wire logic                    stop,
  input wire logic                    readout_done,
  input wire logic                    exposure_active,
  input wire logic                    readout_start,
  input wire logic                    busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`TIME_W-1:0] len_r;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  always @(posedge clock) len_r <= (exposure_active && !rst) ? len_r + 32'h1 : '0;
  a_readout_after_exp: assert property (readout_start |-> $fell(exposure_active))
    else $error("readout start without exposure end");
  a_readout_one_cycle: assert property (readout_start |=> !readout_start)
    else $error("readout start longer than one cycle");
  a_exposure_in_busy: assert property (exposure_active |-> busy)
    else $error("exposure while not busy");
  a_readout_in_busy: assert property (readout_start |-> busy)
    else $error("readout start while not busy");
  a_timed_length: assert property (readout_start && external_start_select != `TRIG_SEL_PULSE
    && exposure_cycles != `TIME_ZERO |-> len_r == exposure_cycles)
    else $error("timed exposure length wrong");
  a_start_level: assert property ($rose(exposure_active) && !$past(busy) && external_start_select
    != `TRIG_SEL_NONE |-> $past(trigger_in, 3) == start_edge_polarity)
    else $error("exposure started without active trigger");
  a_bulb_idle: assert property ((external_start_select == `TRIG_SEL_PULSE
    && trigger_in != start_edge_polarity) [*5] |-> !exposure_active)
    else $error("bulb exposure outlives pulse");
  a_bulb_hold: assert property ($fell(exposure_active) && external_start_select == `TRIG_SEL_PULSE
    && !$past(stop) |-> $past(trigger_in, 3) != start_edge_polarity)
    else $error("bulb exposure ended during pulse");
  c_bulb: cover property ($rose(exposure_active) && external_start_select == `TRIG_SEL_PULSE);
  c_single: cover property (readout_start && frames_per_trigger == `FRAMES_ONE);
  c_free: cover property ($rose(busy) && external_start_select == `TRIG_SEL_NONE);
  c_stream: cover property ($rose(exposure_active) && $past(busy));
endmodule // exposure_seq_properties

// File: exposure_seq_regs.vh
// Constants of the exposure sequencer: mode codes, widths, polarity and zero values.
`ifndef EXPOSURE_SEQ_REGS_VH
`define EXPOSURE_SEQ_REGS_VH
`define TRIG_SEL_NONE     2'h0
`define TRIG_SEL_STANDARD 2'h1
`define TRIG_SEL_PULSE    2'h2
`define FRAME_CNT_W       16
`define TIME_W            32
`define FRAMES_ONE        16'h0001
`define POL_ACTIVE_HIGH   1'h1
`define TIME_ZERO         32'h00000000
`define FRAMES_ZERO       16'h0000
`endif

// File: exposure_seq_tb.sv
// Self-checking bench of the exposure sequencer in every trigger mode.
`include "exposure_seq_regs.vh"
module exposure_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, fire = 0, pol = 1, arm = 0, cap = 0, stop = 0, prev = 0;
  logic [1:0] sel = `TRIG_SEL_NONE;
  logic [`FRAME_CNT_W-1:0] frames = `FRAMES_ONE;
  logic [`TIME_W-1:0] exp_t = 32'h00000006, rep_t = 32'h00000032;
  logic trigger_in, readout_done, exposure_active, readout_start, busy;
  int bad_count = 0, num_checks = 0, cyc = 0, n_exp = 0, width = 0, last = 0, period = 0, base;
  int n_ro = 0, ro_base = 0;
  exposure_seq dut (.clock(clock), .rst(rst), .trigger_in(trigger_in),
    .external_start_select(sel), .start_edge_polarity(pol), .frames_per_trigger(frames),
    .exposure_cycles(exp_t), .repeat_cycles(rep_t), .arm(arm), .capture_start(cap),
    .stop(stop), .readout_done(readout_done), .exposure_active(exposure_active),
    .readout_start(readout_start), .busy(busy));
  trigger_source far (.clock(clock), .rst(rst), .fire(fire), .polarity(pol),
    .readout_start(readout_start), .trigger_in(trigger_in), .readout_done(readout_done));
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    prev <= exposure_active;
    if (readout_start === 1'b1) n_ro <= n_ro + 1;
    if (exposure_active === 1'b1) width <= (prev === 1'b1) ? width + 1 : 1;
    if (exposure_active === 1'b1 && prev !== 1'b1) begin
      n_exp <= n_exp + 1;
      period <= cyc - last;
      last <= cyc;
    end
  end
  task automatic check(string what, logic [31:0] want, logic [31:0] got);
    num_checks++;
    if (want !== got) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, want, got);
    end
  endtask
  task automatic go(int hi, int lo);
    fire <= 1;
    repeat (hi) @(posedge clock);
    fire <= 0;
    repeat (lo) @(posedge clock);
  endtask
  // Stop is held long enough for any readout to drain, so each mode starts from idle.
  task automatic setup(logic [1:0] s, logic p, logic [15:0] f);
    stop <= 1;
    arm <= 0;
    repeat (40) @(posedge clock);
    {sel, pol, frames, stop, arm} <= {s, p, f, 2'h1};
    repeat (5) @(posedge clock);
    base = n_exp;
    ro_base = n_ro;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 0;
    for (int p = 1; p >= 0; p--) begin
      setup(`TRIG_SEL_STANDARD, p[0], `FRAMES_ONE);
      go(10, 2);
      go(40, 40);
      check("single frame count", 1, n_exp - base);
      check("single exposure width", exp_t, width);
      go(5, 40);
      check("next edge frame count", 2, n_exp - base);
    end
    for (int f = 0; f <= 3; f += 3) begin
      setup(`TRIG_SEL_STANDARD, 1'h1, f[15:0]);
      go(5, 60);
      go(5, 100);
      check("stream period", rep_t, period);
      check("stream frame count", 4, n_exp - base);
    end
    setup(`TRIG_SEL_PULSE, 1'h0, `FRAMES_ONE);
    go(25, 6);
    go(5, 40);
    check("bulb width", 25, width);
    check("bulb frame count", 1, n_exp - base);
    check("bulb readout count", 1, n_ro - ro_base);
    setup(`TRIG_SEL_NONE, 1'h1, 16'h0002);
    go(5, 5);
    check("free run trigger count", 0, n_exp - base);
    cap <= 1;
    @(posedge clock);
    cap <= 0;
    repeat (150) @(posedge clock);
    check("free run frame count", 2, n_exp - base);
    check("free run readout count", 2, n_ro - ro_base);
    check("free run busy", 0, busy);
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    print_verdict();
  end
endmodule // exposure_seq_tb
bind exposure_seq exposure_seq_properties chk (.*);

// File: trigger_source.sv
// Far-side model: trigger source plus a readout engine that answers each readout request.
module trigger_source #(parameter int RO_DELAY = 30) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic fire,
  input  wire logic polarity,
  input  wire logic readout_start,
  output logic      trigger_in,
  output logic      readout_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // The length of fire is the pulse width that a bulb exposure must follow.
  assign trigger_in = fire ~^ polarity;
  always @(posedge clock) begin
    readout_done <= !rst && cnt == 1;
    if (rst) cnt <= 0;
    else if (readout_start) cnt <= RO_DELAY;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule // trigger_source
